// ---- shared/wdt_pkg.sv ----
package wdt_pkg;
   // ***************************************************
   // register map
   // ***************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_FLAGS = 8'h00;
   localparam logic [7:0] OFF_WDCTL = 8'h01;
   localparam logic [7:0] OFF_CMPCS = 8'h02;
   localparam int FLAG_SCAN = 4;
   localparam int FLAG_WD = 3;
   localparam int FLAG_UV = 2;
   localparam int FLAG_PIN = 1;
   localparam int FLAG_POR = 0;
   localparam logic [4:0] FLAGS_RESET = 5'h01;
   localparam int WDCTL_CE = 4;
   localparam int WDCTL_EN = 3;
   localparam int PSEL_LSB = 0;
   localparam int PSEL_W = 3;
   localparam logic [2:0] PSEL_RESET = 3'h0;
   localparam int CMPCS_BG = 6;
   // ***************************************************
   // fuse codes
   // ***************************************************
   localparam logic [2:0] UV_OFF = 3'h7;
   localparam logic [2:0] UV_LVL_A = 3'h6;
   localparam logic [2:0] UV_LVL_B = 3'h5;
   localparam logic [2:0] UV_LVL_C = 3'h4;
   localparam logic [2:0] UV_LVL_D = 3'h3;
   localparam logic FUSE_PROG = 1'b0;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int UV_MIN_PULSE_NS = 2000;
   localparam int UV_MIN_CYCLES = (UV_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] CE_HOLD = 3'h4;
   localparam int WDT_CNT_W = 22;
   localparam int WDT_BASE_CYCLES = 16384;
   localparam int STRETCH_W = 20;
   // ***************************************************
   // types
   // ***************************************************
   typedef enum logic [1:0] {
      SAFETY0 = 2'b00,
      SAFETY1 = 2'b01,
      SAFETY2 = 2'b10
   } safety_t;
   typedef enum logic [1:0] {
      RST_IDLE = 2'b00,
      RST_HOLD = 2'b01,
      RST_STRETCH = 2'b10
   } rst_state_t;
   typedef struct packed {
      logic [2:0] uv_level;
      logic compat;
      logic always_on;
   } fuses_t;
   typedef struct packed {
      logic pin_reset;
      logic scan_reset;
      logic uv_low;
   } sources_t;
endpackage

// ---- hdl/undervoltage_filter.sv ----
`timescale 1ns/1ps
module undervoltage_filter #(
   parameter int MIN_CYCLES = wdt_pkg::UV_MIN_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // detector
   input wire logic enable,
   input wire logic uv_low,
   output logic active_reg
);
   localparam int CW = $clog2(MIN_CYCLES + 1);
   localparam logic [CW-1:0] LIMIT = CW'(MIN_CYCLES);
   logic [CW-1:0] cnt_reg;

   // ***************************************************
   // dips no longer than the limit are dropped
   // ***************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (!enable || !uv_low) begin
         cnt_reg <= '0;
      end else if (cnt_reg != LIMIT) begin
         cnt_reg <= cnt_reg + CW'(1);
      end
   end

   // no stretch here: release follows the supply at once
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         active_reg <= 1'b0;
      end else begin
         active_reg <= enable && uv_low && (cnt_reg == LIMIT);
      end
   end
endmodule

// ---- hdl/wdt_counter.sv ----
`timescale 1ns/1ps
module wdt_counter (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // oscillator and control
   input wire logic osc_in,
   input wire logic restart,
   input wire logic [wdt_pkg::PSEL_W-1:0] psel,
   output logic expire_reg
);
   localparam int CW = wdt_pkg::WDT_CNT_W;
   logic osc_s1_reg;
   logic osc_s2_reg;
   logic osc_s3_reg;
   logic tick;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] limit;

   // ***************************************************
   // oscillator edge detect
   // ***************************************************
   // first stage feeds only the second; edge taken after
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_s1_reg <= 1'b0;
         osc_s2_reg <= 1'b0;
         osc_s3_reg <= 1'b0;
      end else begin
         osc_s1_reg <= osc_in;
         osc_s2_reg <= osc_s1_reg;
         osc_s3_reg <= osc_s2_reg;
      end
   end

   assign tick = osc_s2_reg && !osc_s3_reg;
   assign limit = (CW'(wdt_pkg::WDT_BASE_CYCLES) << psel) - CW'(1);

   // ***************************************************
   // counter
   // ***************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         expire_reg <= 1'b0;
      end else if (restart) begin
         cnt_reg <= '0;
         expire_reg <= 1'b0;
      end else if (tick) begin
         if (cnt_reg >= limit) begin
            cnt_reg <= '0;
            expire_reg <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + CW'(1);
            expire_reg <= 1'b0;
         end
      end else begin
         expire_reg <= 1'b0;
      end
   end
endmodule

// ---- hdl/watchdog_and_reset_flags.sv ----
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module watchdog_and_reset_flags #(
   parameter int STRETCH_CYCLES = 65536
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // fuses and reset sources
   input wire wdt_pkg::fuses_t fuses,
   input wire wdt_pkg::sources_t sources,
   // watchdog
   input wire logic wdt_osc,
   input wire logic wdt_restart,
   // register port
   input wire logic [wdt_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata_reg,
   // outputs to the chip
   output logic core_reset_reg,
   output logic wdt_reset_pulse_reg,
   output logic bandgap_enable_reg
);
   // ***************************************************
   // reset release
   // ***************************************************
   logic rst_s1_reg;
   logic rst_n_sync;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_reg <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_sync <= rst_s1_reg;
      end
   end

   // ***************************************************
   // fuse decode
   // ***************************************************
   wdt_pkg::safety_t level;
   logic uv_enable;

   always_comb begin
      if (fuses.always_on == wdt_pkg::FUSE_PROG) begin
         level = wdt_pkg::SAFETY2;
      end else if (fuses.compat == wdt_pkg::FUSE_PROG) begin
         level = wdt_pkg::SAFETY0;
      end else begin
         level = wdt_pkg::SAFETY1;
      end
   end

   // reserved codes are treated as off
   always_comb begin
      unique case (fuses.uv_level)
         wdt_pkg::UV_LVL_A, wdt_pkg::UV_LVL_B,
         wdt_pkg::UV_LVL_C, wdt_pkg::UV_LVL_D: uv_enable = 1'b1;
         default: uv_enable = 1'b0;
      endcase
   end

   // ***************************************************
   // undervoltage qualify
   // ***************************************************
   logic uv_active;

   undervoltage_filter u_uv (
      .mclk(mclk),
      .rst_n(rst_n_sync),
      .enable(uv_enable),
      .uv_low(sources.uv_low),
      .active_reg(uv_active)
   );

   // ***************************************************
   // register writes
   // ***************************************************
   logic wr_flags;
   logic wr_wdctl;
   logic wr_cmpcs;
   logic ce_req;
   logic en_reg;
   logic ce_reg;
   logic [2:0] ce_cnt_reg;
   logic [wdt_pkg::PSEL_W-1:0] psel_reg;
   logic bg_sel_reg;

   assign wr_flags = wr && (addr == wdt_pkg::OFF_FLAGS);
   assign wr_wdctl = wr && (addr == wdt_pkg::OFF_WDCTL);
   assign wr_cmpcs = wr && (addr == wdt_pkg::OFF_CMPCS);
   assign ce_req = wr_wdctl && wdata[wdt_pkg::WDCTL_CE] && wdata[wdt_pkg::WDCTL_EN];

   // change-enable window; a fresh request restarts it
   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ce_reg <= 1'b0;
         ce_cnt_reg <= 3'h0;
      end else if (core_reset_reg) begin
         ce_reg <= 1'b0;
         ce_cnt_reg <= 3'h0;
      end else if (ce_req) begin
         ce_reg <= 1'b1;
         ce_cnt_reg <= wdt_pkg::CE_HOLD;
      end else if (ce_reg) begin
         ce_cnt_reg <= ce_cnt_reg - 3'h1;
         ce_reg <= (ce_cnt_reg != 3'h1);
      end
   end

   // enable returns to the fuse default on every chip reset
   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         en_reg <= 1'b0;
      end else if (level == wdt_pkg::SAFETY2) begin
         en_reg <= 1'b1;
      end else if (core_reset_reg) begin
         en_reg <= 1'b0;
      end else if (wr_wdctl && wdata[wdt_pkg::WDCTL_EN]) begin
         en_reg <= 1'b1;
      end else if (wr_wdctl && ce_reg) begin
         en_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         psel_reg <= wdt_pkg::PSEL_RESET;
      end else if (core_reset_reg) begin
         psel_reg <= wdt_pkg::PSEL_RESET;
      end else if (wr_wdctl && (level == wdt_pkg::SAFETY0 || ce_reg)) begin
         psel_reg <= wdata[wdt_pkg::PSEL_LSB +: wdt_pkg::PSEL_W];
      end
   end

   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         bg_sel_reg <= 1'b0;
      end else if (core_reset_reg) begin
         bg_sel_reg <= 1'b0;
      end else if (wr_cmpcs) begin
         bg_sel_reg <= wdata[wdt_pkg::CMPCS_BG];
      end
   end

   // reference stays on while either user needs it; start-up wait is software's
   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         bandgap_enable_reg <= 1'b0;
      end else begin
         bandgap_enable_reg <= uv_enable || bg_sel_reg;
      end
   end

   // ***************************************************
   // watchdog
   // ***************************************************
   logic wdt_expire;

   wdt_counter u_wdt (
      .mclk(mclk),
      .rst_n(rst_n_sync),
      .osc_in(wdt_osc),
      .restart(wdt_restart || !en_reg || core_reset_reg),
      .psel(psel_reg),
      .expire_reg(wdt_expire)
   );

   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         wdt_reset_pulse_reg <= 1'b0;
      end else begin
         wdt_reset_pulse_reg <= wdt_expire && en_reg;
      end
   end

   // ***************************************************
   // reset sequencing
   // ***************************************************
   localparam int SW = wdt_pkg::STRETCH_W;
   wdt_pkg::rst_state_t state_reg;
   wdt_pkg::rst_state_t state_next;
   logic [SW-1:0] stretch_reg;
   logic any_source;

   assign any_source = sources.pin_reset || sources.scan_reset || uv_active
      || wdt_reset_pulse_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         wdt_pkg::RST_IDLE: begin
            if (any_source) begin
               state_next = wdt_pkg::RST_HOLD;
            end
         end
         wdt_pkg::RST_HOLD: begin
            if (!any_source) begin
               state_next = wdt_pkg::RST_STRETCH;
            end
         end
         wdt_pkg::RST_STRETCH: begin
            if (any_source) begin
               state_next = wdt_pkg::RST_HOLD;
            end else if (stretch_reg == '0) begin
               state_next = wdt_pkg::RST_IDLE;
            end
         end
         default: state_next = wdt_pkg::RST_HOLD;
      endcase
   end

   // power-up begins with a full stretch
   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         state_reg <= wdt_pkg::RST_STRETCH;
         stretch_reg <= SW'(STRETCH_CYCLES - 1);
      end else begin
         state_reg <= state_next;
         if (state_next != wdt_pkg::RST_STRETCH) begin
            stretch_reg <= SW'(STRETCH_CYCLES - 1);
         end else if (state_reg == wdt_pkg::RST_STRETCH) begin
            stretch_reg <= stretch_reg - SW'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         core_reset_reg <= 1'b1;
      end else begin
         core_reset_reg <= (state_next != wdt_pkg::RST_IDLE);
      end
   end

   // ***************************************************
   // reset source flags
   // ***************************************************
   // a set in the same cycle as a clearing write wins
   logic [4:0] flags_reg;
   logic [4:0] flag_set;
   logic [4:0] flag_keep;

   always_comb begin
      flag_set = 5'h00;
      flag_set[wdt_pkg::FLAG_SCAN] = sources.scan_reset;
      flag_set[wdt_pkg::FLAG_WD] = wdt_reset_pulse_reg;
      flag_set[wdt_pkg::FLAG_UV] = uv_active;
      flag_set[wdt_pkg::FLAG_PIN] = sources.pin_reset;
      flag_keep = wr_flags ? wdata[4:0] : 5'h1f;
   end

   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         flags_reg <= wdt_pkg::FLAGS_RESET;
      end else begin
         flags_reg <= (flags_reg & flag_keep) | flag_set;
      end
   end

   // ***************************************************
   // read port
   // ***************************************************
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      if (addr == wdt_pkg::OFF_FLAGS) begin
         rd_mux[4:0] = flags_reg;
      end else if (addr == wdt_pkg::OFF_WDCTL) begin
         rd_mux[wdt_pkg::WDCTL_CE] = ce_reg;
         rd_mux[wdt_pkg::WDCTL_EN] = en_reg;
         rd_mux[wdt_pkg::PSEL_LSB +: wdt_pkg::PSEL_W] = psel_reg;
      end else if (addr == wdt_pkg::OFF_CMPCS) begin
         rd_mux[wdt_pkg::CMPCS_BG] = bg_sel_reg;
      end
   end

   // data only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rd ? rd_mux : 8'h00;
      end
   end
endmodule

// ---- tb/watchdog_and_reset_flags_monitor.sv ----
`timescale 1ns/1ps
module watchdog_and_reset_flags_monitor #(
   parameter int STRETCH_CYCLES = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // fuses and sources
   input wire wdt_pkg::fuses_t fuses,
   input wire wdt_pkg::sources_t sources,
   // watchdog
   input wire logic wdt_osc,
   input wire logic wdt_restart,
   // register port
   input wire logic [wdt_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata_reg,
   // chip outputs
   input wire logic core_reset_reg,
   input wire logic wdt_reset_pulse_reg,
   input wire logic bandgap_enable_reg
);
   // ****
   // helpers
   // ****
   // runs one flop past the two-flop release, so the first edges are not judged
   logic [2:0] up_reg;
   logic [3:0] ce_age_reg;
   logic [6:0] uv_cnt_reg;
   logic uv_on;
   logic wd_acc;
   assign uv_on = fuses.uv_level inside {wdt_pkg::UV_LVL_A, wdt_pkg::UV_LVL_B,
      wdt_pkg::UV_LVL_C, wdt_pkg::UV_LVL_D};
   assign wd_acc = addr == wdt_pkg::OFF_WDCTL;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) up_reg <= 3'h0;
      else up_reg <= {up_reg[1:0], 1'b1};
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) ce_age_reg <= 4'hf;
      else if (wr && wd_acc && wdata[4] && wdata[3]) ce_age_reg <= 4'h0;
      else if (ce_age_reg != 4'hf) ce_age_reg <= ce_age_reg + 4'h1;
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) uv_cnt_reg <= 7'h00;
      else if (!sources.uv_low) uv_cnt_reg <= 7'h00;
      else if (uv_cnt_reg != 7'h7f) uv_cnt_reg <= uv_cnt_reg + 7'h01;
   end
   // cycles since any reset source was last seen
   logic [19:0] quiet_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         quiet_reg <= 20'h00000;
      end else if (sources.pin_reset || sources.scan_reset || sources.uv_low
         || wdt_reset_pulse_reg) begin
         quiet_reg <= 20'h00000;
      end else if (quiet_reg != 20'hfffff) begin
         quiet_reg <= quiet_reg + 20'h00001;
      end
   end
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!up_reg[2]);
   // ****
   // checks
   // ****
   property p_pulse_one;
      wdt_reset_pulse_reg |=> !wdt_reset_pulse_reg;
   endproperty
   a_pulse_one: assert property (p_pulse_one)
      else $error("expiry pulse longer than one cycle");
   property p_pulse_hold;
      wdt_reset_pulse_reg |=> core_reset_reg [*8];
   endproperty
   a_pulse_hold: assert property (p_pulse_hold)
      else $error("core not held after expiry pulse");
   property p_rsv_zero;
      rd && wd_acc |=> rdata_reg[7:5] == 3'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("control bits 7..5 not zero");
   property p_lvl2_en;
      rd && wd_acc && fuses.always_on == wdt_pkg::FUSE_PROG && !core_reset_reg
         |=> rdata_reg[wdt_pkg::WDCTL_EN];
   endproperty
   a_lvl2_en: assert property (p_lvl2_en)
      else $error("enable reads zero at level 2");
   property p_bandgap;
      uv_on && $stable(fuses) |=> bandgap_enable_reg;
   endproperty
   a_bandgap: assert property (p_bandgap)
      else $error("bandgap off with detector on");
   property p_uv_short;
      $rose(sources.uv_low) && !core_reset_reg |=> !core_reset_reg [*8];
   endproperty
   a_uv_short: assert property (p_uv_short)
      else $error("undervoltage reset without filtering");
   property p_uv_long;
      uv_on && uv_cnt_reg == 7'h56 |-> core_reset_reg;
   endproperty
   a_uv_long: assert property (p_uv_long)
      else $error("long undervoltage gave no reset");
   property p_ce_clear;
      rd && wd_acc && ce_age_reg >= 4'h4 |=> !rdata_reg[wdt_pkg::WDCTL_CE];
   endproperty
   a_ce_clear: assert property (p_ce_clear)
      else $error("change enable not cleared in time");
   property p_release;
      $fell(core_reset_reg) |-> quiet_reg >= 20'(STRETCH_CYCLES);
   endproperty
   a_release: assert property (p_release)
      else $error("core released before stretch delay");
endmodule
bind watchdog_and_reset_flags watchdog_and_reset_flags_monitor #(
   .STRETCH_CYCLES(STRETCH_CYCLES)
) mon (.mclk(mclk), .reset_n(reset_n), .fuses(fuses), .sources(sources),
   .wdt_osc(wdt_osc), .wdt_restart(wdt_restart), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata_reg(rdata_reg), .core_reset_reg(core_reset_reg),
   .wdt_reset_pulse_reg(wdt_reset_pulse_reg),
   .bandgap_enable_reg(bandgap_enable_reg));

// ---- tb/core_model.sv ----
`timescale 1ns/1ps
module core_model (
   // clock
   input wire logic mclk,
   // register port
   output logic [wdt_pkg::ADDR_W-1:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [7:0] rdata_reg,
   // restart instruction
   output logic wdt_restart
);
   // ****
   // bus cycles
   // ****
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdt_restart = 1'b0;
   end
   // idle address and data are inverted so stale values never look valid
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      addr <= ~a;
      #1 d = rdata_reg;
   endtask
   task automatic restart();
      @(posedge mclk);
      wdt_restart <= 1'b1;
      @(posedge mclk);
      wdt_restart <= 1'b0;
   endtask
   task automatic wdt_off();
      wr_reg(wdt_pkg::OFF_WDCTL, 8'h18);
      wr_reg(wdt_pkg::OFF_WDCTL, 8'h00);
   endtask
   // worst-case start-up at 40 MHz, costly but safe
   task automatic bg_on();
      wr_reg(wdt_pkg::OFF_CMPCS, 8'h40);
      repeat (2800) @(posedge mclk);
   endtask
endmodule

// ---- tb/watchdog_and_reset_flags_tb.sv ----
`timescale 1ns/1ps
module watchdog_and_reset_flags_tb;
   // ****
   // bench
   // ****
   localparam int STRETCH = 16;
   localparam logic [7:0] A_FL = wdt_pkg::OFF_FLAGS;
   localparam logic [7:0] A_WD = wdt_pkg::OFF_WDCTL;
   localparam logic [7:0] A_CS = wdt_pkg::OFF_CMPCS;
   logic mclk;
   logic reset_n;
   logic wdt_osc;
   logic osc_run;
   wdt_pkg::fuses_t fuses;
   wdt_pkg::sources_t sources;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic wdt_restart;
   logic [7:0] rdata_reg;
   logic core_reset_reg;
   logic wdt_reset_pulse_reg;
   logic bandgap_enable_reg;
   int n_fail;
   int checks;
   int n;
   watchdog_and_reset_flags #(.STRETCH_CYCLES(STRETCH)) dut (.mclk(mclk),
      .reset_n(reset_n), .fuses(fuses), .sources(sources), .wdt_osc(wdt_osc),
      .wdt_restart(wdt_restart), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_reg(rdata_reg), .core_reset_reg(core_reset_reg),
      .wdt_reset_pulse_reg(wdt_reset_pulse_reg),
      .bandgap_enable_reg(bandgap_enable_reg));
   core_model core (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_reg(rdata_reg), .wdt_restart(wdt_restart));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // oscillator sped up to 4 clocks a tick so one expiry fits the run
   initial begin
      wdt_osc = 1'b0;
      forever begin
         repeat (2) @(posedge mclk);
         if (osc_run) wdt_osc <= ~wdt_osc;
      end
   end
   function automatic wdt_pkg::fuses_t mk(input logic [2:0] l, input logic c,
      input logic a);
      return {l, c, a};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      core.rd_reg(a, v);
      chk(v, exp);
   endtask
   task automatic wait_core(input logic val);
      n = 0;
      while (core_reset_reg !== val && n < 300) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk({7'h00, core_reset_reg}, {7'h00, val});
   endtask
   task automatic do_reset(input wdt_pkg::fuses_t f);
      @(posedge mclk);
      reset_n <= 1'b0;
      fuses <= f;
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      wait_core(1'b0);
   endtask
   task automatic dip(input logic [2:0] s, input int len);
      @(posedge mclk);
      sources <= wdt_pkg::sources_t'(s);
      repeat (len) @(posedge mclk);
      sources <= '0;
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #(90000 * 25);
      n_fail++;
      $display("wrong value at %0t: timeout", $time);
      report_and_stop();
   end
   // ****
   // tests
   // ****
   initial begin
      reset_n = 1'b0;
      fuses = mk(wdt_pkg::UV_OFF, 1'b1, 1'b1);
      sources = '0;
      osc_run = 1'b0;
      n_fail = 0;
      checks = 0;
      do_reset(mk(wdt_pkg::UV_OFF, 1'b1, 1'b1));
      rdchk(A_FL, 8'h01);
      rdchk(A_WD, 8'h00);
      chk({7'h00, bandgap_enable_reg}, 8'h00);
      core.wr_reg(A_FL, 8'h00);
      rdchk(A_FL, 8'h00);
      core.bg_on();
      chk({7'h00, bandgap_enable_reg}, 8'h01);
      core.wr_reg(A_CS, 8'h00);
      rdchk(A_CS, 8'h00);
      chk({7'h00, bandgap_enable_reg}, 8'h00);
      core.wr_reg(A_WD, 8'hef);
      rdchk(A_WD, 8'h08);
      core.wr_reg(A_WD, 8'h00);
      rdchk(A_WD, 8'h08);
      core.wr_reg(A_WD, 8'h18);
      repeat (3) @(posedge mclk);
      core.wr_reg(A_WD, 8'h00);
      rdchk(A_WD, 8'h08);
      core.wdt_off();
      rdchk(A_WD, 8'h10);
      core.wr_reg(A_WD, 8'h18);
      core.wr_reg(A_WD, 8'h0b);
      repeat (4) @(posedge mclk);
      rdchk(A_WD, 8'h0b);
      do_reset(mk(wdt_pkg::UV_OFF, 1'b1, 1'b0));
      rdchk(A_WD, 8'h08);
      core.wdt_off();
      rdchk(A_WD, 8'h18);
      do_reset(mk(wdt_pkg::UV_OFF, 1'b0, 1'b1));
      core.wr_reg(A_WD, 8'h0b);
      rdchk(A_WD, 8'h0b);
      core.wr_reg(A_FL, 8'h00);
      for (int i = 0; i < 2; i++) begin
         dip(i ? 3'h2 : 3'h4, 3);
         wait_core(1'b1);
         wait_core(1'b0);
         chk(8'(n >= STRETCH), 8'h01);
         rdchk(A_FL, i ? 8'h10 : 8'h02);
         rdchk(A_WD, 8'h00);
         core.wr_reg(A_FL, 8'h00);
      end
      for (int i = 0; i < 2; i++) begin
         do_reset(mk(i ? 3'h2 : wdt_pkg::UV_OFF, 1'b0, 1'b1));
         dip(3'h1, 120);
         repeat (3) @(posedge mclk);
         rdchk(A_FL, 8'h01);
         chk({7'h00, bandgap_enable_reg}, 8'h00);
      end
      do_reset(mk(wdt_pkg::UV_LVL_B, 1'b0, 1'b1));
      chk({7'h00, bandgap_enable_reg}, 8'h01);
      core.wr_reg(A_FL, 8'h00);
      dip(3'h1, 40);
      repeat (3) @(posedge mclk);
      rdchk(A_FL, 8'h00);
      dip(3'h1, 120);
      #1 chk({7'h00, core_reset_reg}, 8'h01);
      wait_core(1'b0);
      chk(8'(n >= STRETCH), 8'h01);
      rdchk(A_FL, 8'h04);
      do_reset(mk(wdt_pkg::UV_OFF, 1'b0, 1'b1));
      core.wr_reg(A_FL, 8'h00);
      core.wr_reg(A_WD, 8'h08);
      osc_run = 1'b1;
      repeat (3000) @(posedge mclk);
      core.restart();
      n = 0;
      while (wdt_reset_pulse_reg !== 1'b1 && n < 70000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(8'(n > 65500 && n < 65580), 8'h01);
      osc_run = 1'b0;
      wait_core(1'b1);
      wait_core(1'b0);
      chk(8'(n >= STRETCH), 8'h01);
      rdchk(A_FL, 8'h08);
      rdchk(A_WD, 8'h00);
      report_and_stop();
   end
endmodule
